// ===== rtl/nfc_pkg.sv
// nfc_pkg: constants, command codes and carrier types for the nor flash host controller
// assumes a 100 MHz system clock and a parallel nor flash with an asynchronous bus
package nfc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // command addresses and data of the unlock and command bus cycles
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h2AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] PROG_CMD = 8'hA0;
  localparam logic [7:0] ERASE_SETUP_CMD = 8'h80;
  localparam logic [7:0] SECTOR_ERASE_CMD = 8'h30;
  localparam logic [7:0] CHIP_ERASE_CMD = 8'h10;
  // protect select patterns on address bits 6,3,2,1,0
  localparam logic [4:0] PROTECT_PATTERN = 5'h02;
  localparam logic [4:0] UNPROTECT_PATTERN = 5'h12;
  // status bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int SUSP_TOGGLE_BIT = 2;
  // bus phase lengths in ns, reset hold in us, and all in cycles (least times, rounded up)
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_HIGH_NS = 25;
  localparam int READ_ACC_NS = 70;
  localparam int RRB_US = 4;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_ACC_CYC = (READ_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int RRB_CYC = RRB_US * CLK_MHZ;
  localparam int TMR_W = 12;
  // software register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_IRQ = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h5;
  localparam logic [3:0] REG_RDATA = 4'h6;
  // ctrl op field
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_SECT = 3'h2;
  localparam logic [2:0] OP_CHIP = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] OP_PROT = 3'h5;
  localparam logic [2:0] OP_UNPROT = 3'h6;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nfc_cycle_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } nfc_strobe_t;
endpackage : nfc_pkg

// ===== rtl/nfc_seq_rom.sv
// nfc_seq_rom: table of bus cycles for each command sequence, registered read
// assumes the caller holds the index stable for one cycle before using the data
`timescale 1ns/1ps
module nfc_seq_rom (
  input wire logic clk_sys_i, // system clock
  input wire logic ce_i, // clock enable
  input wire logic [2:0] op_i, // operation
  input wire logic [2:0] step_i, // cycle index within sequence
  output nfc_pkg::nfc_cycle_t cyc_o // registered address and data
);
  nfc_pkg::nfc_cycle_t next_cyc;
  nfc_pkg::nfc_cycle_t cyc;

  function automatic nfc_pkg::nfc_cycle_t mk(input logic [11:0] a, input logic [7:0] d);
    mk.addr = {8'h00, a};
    mk.data = {8'h00, d};
  endfunction : mk

  always_comb begin
    next_cyc = mk(nfc_pkg::UNLOCK1_ADDR, nfc_pkg::UNLOCK1_DATA);
    case (step_i)
      3'h0: next_cyc = mk(nfc_pkg::UNLOCK1_ADDR, nfc_pkg::UNLOCK1_DATA);
      3'h1: next_cyc = mk(nfc_pkg::UNLOCK2_ADDR, nfc_pkg::UNLOCK2_DATA);
      3'h2: begin
        if (op_i == nfc_pkg::OP_PROG) begin
          next_cyc = mk(nfc_pkg::UNLOCK1_ADDR, nfc_pkg::PROG_CMD);
        end else begin
          next_cyc = mk(nfc_pkg::UNLOCK1_ADDR, nfc_pkg::ERASE_SETUP_CMD);
        end
      end
      3'h3: next_cyc = mk(nfc_pkg::UNLOCK1_ADDR, nfc_pkg::UNLOCK1_DATA);
      3'h4: next_cyc = mk(nfc_pkg::UNLOCK2_ADDR, nfc_pkg::UNLOCK2_DATA);
      3'h5: begin
        if (op_i == nfc_pkg::OP_CHIP) begin
          next_cyc = mk(nfc_pkg::UNLOCK1_ADDR, nfc_pkg::CHIP_ERASE_CMD);
        end else begin
          next_cyc = mk(12'h000, nfc_pkg::SECTOR_ERASE_CMD);
        end
      end
      default: next_cyc = mk(12'h000, 8'h00);
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      cyc <= next_cyc;
    end
  end

  assign cyc_o = cyc;
endmodule : nfc_seq_rom

// ===== rtl/nfc_host.sv
// nfc_host: host controller that issues program, erase, read and protect cycles to a nor flash
// assumes the flash pins are asynchronous; data and busy inputs are synchronised here
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module nfc_host #(
  parameter int RRB_CYCLES = nfc_pkg::RRB_CYC // reset hold after busy rises
) (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic ce_i, // clock enable
  input wire logic [3:0] addr_i, // register address
  input wire logic [31:0] wdata_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after rd_i
  output logic irq_o, // level interrupt
  output logic [nfc_pkg::ADDR_W-1:0] fl_addr_o, // flash address
  output logic [nfc_pkg::DATA_W-1:0] fl_dq_o, // flash data out
  output logic fl_dq_oe_o, // flash data output enable
  input wire logic [nfc_pkg::DATA_W-1:0] fl_dq_i, // flash data in
  output nfc_pkg::nfc_strobe_t fl_strb_o, // chip, output, write enables (low)
  output logic fl_reset_n_o, // flash reset, low
  output logic fl_hv_reset_o, // request high voltage on reset
  input wire logic busy_indicator_n_i // ready high, busy low
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_WLOW = 3'h1, ST_WHIGH = 3'h2, ST_RLOW = 3'h3,
    ST_RHIGH = 3'h4, ST_WAIT = 3'h5, ST_HOLD = 3'h6
  } nfc_st_t;

  nfc_st_t st, next_st;
  logic [2:0] op, next_op;
  logic [2:0] step, next_step;
  logic [nfc_pkg::TMR_W-1:0] tmr, next_tmr;
  logic [nfc_pkg::ADDR_W-1:0] tgt_addr, next_tgt_addr;
  logic [nfc_pkg::DATA_W-1:0] tgt_data, next_tgt_data;
  logic [nfc_pkg::DATA_W-1:0] rdata_q, next_rdata_q;
  logic [nfc_pkg::DATA_W-1:0] prev_q, next_prev_q;
  logic first_rd, next_first_rd;
  logic [3:0] irq_st, next_irq_st;
  logic [3:0] irq_mask, next_irq_mask;
  logic hv, next_hv;
  logic [31:0] rdata, next_rdata;
  nfc_pkg::nfc_strobe_t strb, next_strb;
  logic dq_oe, next_dq_oe;
  logic [nfc_pkg::ADDR_W-1:0] fa, next_fa;
  logic [nfc_pkg::DATA_W-1:0] fd, next_fd;
  logic [nfc_pkg::DATA_W-1:0] dq_s1, dq_s2;
  logic by_s1, by_s2;
  nfc_pkg::nfc_cycle_t rom_cyc;
  logic ev_done, ev_fail;
  logic [2:0] last_step;

  nfc_seq_rom u_rom (
    .clk_sys_i(clk_sys_i),
    .ce_i(ce_i),
    .op_i(op),
    .step_i(step),
    .cyc_o(rom_cyc)
  );

  // two-stage synchronisers for the asynchronous flash inputs
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      dq_s1 <= fl_dq_i;
      dq_s2 <= dq_s1;
      by_s1 <= busy_indicator_n_i;
      by_s2 <= by_s1;
    end
  end

  function automatic logic is_cmd(input logic [2:0] o);
    is_cmd = (o == nfc_pkg::OP_PROG) || (o == nfc_pkg::OP_SECT) || (o == nfc_pkg::OP_CHIP);
  endfunction : is_cmd

  // address lines 6,3,2,1,0 for the protect cycle
  function automatic logic [nfc_pkg::ADDR_W-1:0] prot_addr(input logic [nfc_pkg::ADDR_W-1:0] a,
                                                           input logic [4:0] p);
    logic [nfc_pkg::ADDR_W-1:0] r;
    r = a;
    r[6] = p[4];
    r[3:0] = p[3:0];
    prot_addr = r;
  endfunction : prot_addr

  assign last_step = (op == nfc_pkg::OP_PROG) ? 3'h3 : 3'h5;

  always_comb begin
    next_st = st;
    next_op = op;
    next_step = step;
    next_tmr = tmr;
    next_tgt_addr = tgt_addr;
    next_tgt_data = tgt_data;
    next_rdata_q = rdata_q;
    next_prev_q = prev_q;
    next_first_rd = first_rd;
    next_hv = hv;
    next_strb = strb;
    next_dq_oe = dq_oe;
    next_fa = fa;
    next_fd = fd;
    ev_done = 1'b0;
    ev_fail = 1'b0;
    case (st)
      ST_IDLE: begin
        next_strb = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        next_dq_oe = 1'b0;
        if (wr_i && addr_i == nfc_pkg::REG_CTRL && wdata_i[2:0] != 3'h0) begin
          next_op = wdata_i[2:0];
          next_step = 3'h0;
          next_hv = wdata_i[3];
          next_first_rd = 1'b1;
          next_tmr = '0;
          next_st = (wdata_i[2:0] == nfc_pkg::OP_READ) ? ST_RLOW : ST_WHIGH;
        end
      end
      ST_WHIGH: begin
        // write strobe high phase; also lets the table register settle
        next_strb.we_n = 1'b1;
        next_tmr = tmr + 1'b1;
        if (tmr >= nfc_pkg::TMR_W'(nfc_pkg::WRITE_HIGH_CYC)) begin
          next_tmr = '0;
          next_st = ST_WLOW;
          next_dq_oe = 1'b1;
          if (op == nfc_pkg::OP_PROT || op == nfc_pkg::OP_UNPROT) begin
            next_fa = prot_addr(tgt_addr, op == nfc_pkg::OP_PROT ? nfc_pkg::PROTECT_PATTERN
                                                             : nfc_pkg::UNPROTECT_PATTERN);
            next_fd = tgt_data;
          end else if (op == nfc_pkg::OP_PROG && step == 3'h3) begin
            next_fa = tgt_addr;
            next_fd = tgt_data;
          end else if (op == nfc_pkg::OP_SECT && step == 3'h5) begin
            next_fa = tgt_addr;
            next_fd = rom_cyc.data;
          end else begin
            next_fa = rom_cyc.addr;
            next_fd = rom_cyc.data;
          end
          // address and data change on the same edge as both enables fall, data held past both rises
          next_strb = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
        end
      end
      ST_WLOW: begin
        next_tmr = tmr + 1'b1;
        if (tmr >= nfc_pkg::TMR_W'(nfc_pkg::WRITE_PULSE_CYC)) begin
          next_tmr = '0;
          next_strb = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
          if (!is_cmd(op) || step == last_step) begin
            next_st = ST_WAIT;
          end else begin
            next_step = step + 3'h1;
            next_st = ST_WHIGH;
          end
        end
      end
      ST_WAIT: begin
        // data bus is released after the rise so the device never sees a moving value
        next_dq_oe = 1'b0;
        next_tmr = tmr + 1'b1;
        if (tmr >= nfc_pkg::TMR_W'(4) && by_s2) begin
          next_tmr = '0;
          next_st = hv ? ST_HOLD : ST_RLOW;
        end
      end
      ST_HOLD: begin
        next_tmr = tmr + 1'b1;
        if (tmr >= nfc_pkg::TMR_W'(RRB_CYCLES)) begin
          next_tmr = '0;
          next_hv = 1'b0;
          next_st = ST_RLOW;
        end
      end
      ST_RLOW: begin
        // each poll is a fresh enable pulse so the device advances its toggles
        next_fa = tgt_addr;
        next_strb = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
        next_dq_oe = 1'b0;
        next_tmr = tmr + 1'b1;
        if (tmr >= nfc_pkg::TMR_W'(nfc_pkg::READ_ACC_CYC + 2)) begin
          next_tmr = '0;
          next_prev_q = rdata_q;
          next_rdata_q = dq_s2;
          next_st = ST_RHIGH;
        end
      end
      ST_RHIGH: begin
        next_strb = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        next_tmr = tmr + 1'b1;
        if (tmr >= nfc_pkg::TMR_W'(nfc_pkg::WRITE_HIGH_CYC)) begin
          next_tmr = '0;
          if (op == nfc_pkg::OP_READ || !is_cmd(op)) begin
            ev_done = 1'b1;
            next_st = ST_IDLE;
          end else if (!first_rd && prev_q[nfc_pkg::TOGGLE_BIT] == rdata_q[nfc_pkg::TOGGLE_BIT]) begin
            // toggle stopped: for a program, check the polling bit against the written value
            ev_done = 1'b1;
            ev_fail = (op == nfc_pkg::OP_PROG) &&
                      (rdata_q[nfc_pkg::POLL_BIT] != tgt_data[nfc_pkg::POLL_BIT]);
            next_st = ST_IDLE;
          end else begin
            // first poll of an operation has nothing to compare against yet
            next_first_rd = 1'b0;
            next_st = ST_RLOW;
          end
        end
      end
      default: next_st = ST_IDLE;
    endcase
    if (wr_i && addr_i == nfc_pkg::REG_ADDR && st == ST_IDLE) begin
      next_tgt_addr = wdata_i[nfc_pkg::ADDR_W-1:0];
    end
    if (wr_i && addr_i == nfc_pkg::REG_DATA && st == ST_IDLE) begin
      next_tgt_data = wdata_i[nfc_pkg::DATA_W-1:0];
    end
  end

  // registers only; prev_q takes the old sample as rdata_q takes the new one
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
      op <= 3'h0;
      step <= 3'h0;
      tmr <= '0;
      tgt_addr <= '0;
      tgt_data <= '0;
      rdata_q <= '0;
      prev_q <= '0;
      first_rd <= 1'b1;
      hv <= 1'b0;
      strb <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      dq_oe <= 1'b0;
      fa <= '0;
      fd <= '0;
    end else if (ce_i) begin
      st <= next_st;
      op <= next_op;
      step <= next_step;
      tmr <= next_tmr;
      tgt_addr <= next_tgt_addr;
      tgt_data <= next_tgt_data;
      rdata_q <= next_rdata_q;
      prev_q <= next_prev_q;
      first_rd <= next_first_rd;
      hv <= next_hv;
      strb <= next_strb;
      dq_oe <= next_dq_oe;
      fa <= next_fa;
      fd <= next_fd;
    end
  end

  // register file: bit0 done, bit1 fail, bit2 busy seen, bit3 reserved
  always_comb begin
    next_irq_st = irq_st;
    next_irq_mask = irq_mask;
    next_rdata = 32'h0000_0000;
    if (wr_i && addr_i == nfc_pkg::REG_IRQ) begin
      next_irq_st = irq_st & ~wdata_i[3:0];
    end
    if (wr_i && addr_i == nfc_pkg::REG_MASK) begin
      next_irq_mask = wdata_i[3:0];
    end
    // set wins over a clear in the same cycle
    next_irq_st = next_irq_st | {1'b0, (st == ST_WAIT && !by_s2), ev_fail, ev_done};
    if (rd_i) begin
      case (addr_i)
        nfc_pkg::REG_CTRL: next_rdata = {28'h0, hv, op};
        nfc_pkg::REG_ADDR: next_rdata = {12'h000, tgt_addr};
        nfc_pkg::REG_DATA: next_rdata = {16'h0000, tgt_data};
        nfc_pkg::REG_STATUS: next_rdata = {27'h0, by_s2, st != ST_IDLE, st};
        nfc_pkg::REG_IRQ: next_rdata = {28'h0, irq_st};
        nfc_pkg::REG_MASK: next_rdata = {28'h0, irq_mask};
        nfc_pkg::REG_RDATA: next_rdata = {16'h0000, rdata_q};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_st <= 4'h0;
      irq_mask <= 4'h0;
      rdata <= 32'h0000_0000;
    end else if (ce_i) begin
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;
  assign irq_o = |(irq_st & irq_mask);
  assign fl_addr_o = fa;
  assign fl_dq_o = fd;
  assign fl_dq_oe_o = dq_oe;
  assign fl_strb_o = strb;
  assign fl_reset_n_o = ~rst_i;
  assign fl_hv_reset_o = hv;

  a_write_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(strb.we_n) |-> (!strb.ce_n && dq_oe && !strb.we_n) [*4])
    else $error("write pulse too short or enables apart");
  a_read_no_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !strb.oe_n |-> !dq_oe)
    else $error("data driven during read");
  a_prot_pattern: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (op == nfc_pkg::OP_PROT && !strb.we_n) |-> (fa[6] == 1'b0 && fa[3:0] == 4'h2))
    else $error("protect address pattern wrong");
  a_unprot_pattern: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (op == nfc_pkg::OP_UNPROT && !strb.we_n) |-> (fa[6] == 1'b1 && fa[3:0] == 4'h2))
    else $error("unprotect address pattern wrong");
  a_hv_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    ($fell(hv) && !$past(rst_i)) |-> ($past(st) == ST_HOLD && $past(tmr) >= nfc_pkg::TMR_W'(RRB_CYCLES)))
    else $error("high voltage dropped early");
  a_busy_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st == ST_WAIT && !by_s2) |=> st == ST_WAIT)
    else $error("left wait while busy");
  a_prog_last: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (op == nfc_pkg::OP_PROG && step == 3'h2 && !strb.we_n) |-> fd[7:0] == nfc_pkg::PROG_CMD)
    else $error("program command missing");
  a_erase_last: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (op == nfc_pkg::OP_CHIP && step == 3'h5 && !strb.we_n) |-> fd[7:0] == nfc_pkg::CHIP_ERASE_CMD)
    else $error("chip erase command missing");
endmodule : nfc_host

// ===== tb/nfc_flash_model.sv
// nfc_flash_model: behavioural nor flash that answers the host's bus cycles
// assumes glitch free strobes from the host; no clock, busy times in ns, shortened
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter int PROG_NS = 600, // program busy time, prompt
  parameter int ERASE_NS = 2500 // erase busy time, slow
) (
  input wire logic [19:0] addr_i, // flash address
  input wire logic [15:0] dq_i, // data bus level
  input nfc_pkg::nfc_strobe_t strb_i, // enables, active low
  output logic [15:0] dq_o, // data driven to the host
  output logic busy_n_o, // ready high, busy low
  output logic [4:0] prot_pat_o // lines 6,3..0 of the last write
);
  logic [15:0] mem [int];
  int kill [$];
  logic [15:0] last_val, hold_val, prev_d;
  logic [11:0] prev_a;
  logic arm_prog, tgl, stgl;
  wire wr_act = ~strb_i.ce_n & ~strb_i.we_n;
  wire rd_act = ~strb_i.ce_n & ~strb_i.oe_n;

  initial begin
    busy_n_o = 1'b1;
    arm_prog = 1'b0;
    tgl = 1'b0;
    stgl = 1'b0;
    hold_val = 16'h0000;
    last_val = 16'hFFFF;
    prev_a = 12'h000;
    prev_d = 16'h0000;
  end

  task automatic start_erase();
    last_val = 16'hFFFF;
    busy_n_o = 1'b0;
    busy_n_o <= #(ERASE_NS) 1'b1;
  endtask : start_erase

  // address and data taken when the first strobe rises; both are stable by then
  always @(negedge wr_act) begin
    prot_pat_o = {addr_i[6], addr_i[3:0]};
    if (busy_n_o && arm_prog) begin
      mem[addr_i] = dq_i;
      last_val = dq_i;
      arm_prog = 1'b0;
      busy_n_o = 1'b0;
      busy_n_o <= #(PROG_NS) 1'b1;
    end else if (busy_n_o) begin
      arm_prog = (dq_i[7:0] == nfc_pkg::PROG_CMD) && (addr_i[11:0] == nfc_pkg::UNLOCK1_ADDR);
      if (prev_a == nfc_pkg::UNLOCK2_ADDR && prev_d[7:0] == nfc_pkg::UNLOCK2_DATA) begin
        if (dq_i[7:0] == nfc_pkg::SECTOR_ERASE_CMD) begin
          foreach (mem[k]) if (k[19:15] == addr_i[19:15]) kill.push_back(k);
          foreach (kill[i]) mem.delete(kill[i]);
          kill.delete();
          start_erase();
        end else if (dq_i[7:0] == nfc_pkg::CHIP_ERASE_CMD && addr_i[11:0] == nfc_pkg::UNLOCK1_ADDR) begin
          mem.delete();
          start_erase();
        end
      end
      prev_a = addr_i[11:0];
      prev_d = dq_i;
    end
  end

  // a new read while busy, opened by either enable, advances the toggle bit
  always @(posedge rd_act) if (!busy_n_o) tgl = ~tgl;
  // no erase is ever suspended here, so the suspend toggle bit never moves
  always @(negedge rd_act) hold_val = dq_o;
  always @(rd_act, busy_n_o, tgl, addr_i, hold_val) begin
    if (!rd_act) begin
      dq_o = ~hold_val; // released bus must not look like the last word
    end else if (!busy_n_o) begin
      dq_o = {8'h00, ~last_val[7], tgl, 3'b000, stgl, 2'b00};
    end else begin
      dq_o = mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
    end
  end
endmodule : nfc_flash_model

// ===== tb/tb_top.sv
// tb_top: self-checking bench for nfc_host against the behavioural flash model
// assumes ce_i held high except for one register write; hv hold count shortened through RRB_CYCLES
`timescale 1ns/1ps
module tb_top;
  localparam int RRB = 8;
  typedef struct {
    logic [2:0] op;
    logic [19:0] a;
    logic [15:0] d;
    logic [19:0] ra;
    logic [15:0] exp;
  } nfc_row_t;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o, got;
  logic irq_o, fl_dq_oe_o, fl_reset_n_o, fl_hv_reset_o, busy_n;
  logic [19:0] fl_addr_o;
  logic [15:0] fl_dq_o, dq_dev, dq_bus;
  logic [4:0] prot_pat;
  nfc_pkg::nfc_strobe_t fl_strb_o;
  int error_cnt = 0;
  int num_checks = 0;
  int hi_cnt = 0;
  int hv_falls = 0;
  nfc_row_t rows [5] = '{
    '{nfc_pkg::OP_PROG, 20'h00123, 16'h5AA5, 20'h00123, 16'h5AA5},
    '{nfc_pkg::OP_PROG, 20'h08010, 16'h0F0F, 20'h08010, 16'h0F0F},
    '{nfc_pkg::OP_SECT, 20'h00000, 16'h0000, 20'h00123, 16'hFFFF},
    '{nfc_pkg::OP_PROG, 20'h08020, 16'h8001, 20'h08010, 16'h0F0F},
    '{nfc_pkg::OP_CHIP, 20'h00000, 16'h0000, 20'h08010, 16'hFFFF}
  };

  always #5 clk_sys_i = ~clk_sys_i;
  assign dq_bus = fl_dq_oe_o ? fl_dq_o : dq_dev;

  nfc_host #(.RRB_CYCLES(RRB)) u_nfc_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_dq_i(dq_bus),
    .fl_strb_o(fl_strb_o), .fl_reset_n_o(fl_reset_n_o), .fl_hv_reset_o(fl_hv_reset_o),
    .busy_indicator_n_i(busy_n));
  nfc_flash_model u_nfc_flash_model (.addr_i(fl_addr_o), .dq_i(dq_bus), .strb_i(fl_strb_o),
    .dq_o(dq_dev), .busy_n_o(busy_n), .prot_pat_o(prot_pat));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    got = rdata_o;
  endtask : reg_rd

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check(32'(n < 2000), 32'h1);
  endtask : wait_irq

  task automatic run_op(input logic hv, input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
    reg_wr(nfc_pkg::REG_ADDR, {12'h0, a});
    reg_wr(nfc_pkg::REG_DATA, {16'h0, d});
    reg_wr(nfc_pkg::REG_CTRL, {28'h0, hv, op});
    wait_irq();
    reg_rd(nfc_pkg::REG_IRQ);
    check({31'h0, got[0]}, 32'h1);
    if (op inside {nfc_pkg::OP_PROG, nfc_pkg::OP_SECT, nfc_pkg::OP_CHIP}) begin
      check({31'h0, got[2]}, 32'h1);
      check({31'h0, got[1]}, 32'h0);
    end
    reg_wr(nfc_pkg::REG_IRQ, 32'h7);
  endtask : run_op

  // reset must hold long enough after busy returns before the high level is dropped
  always @(posedge clk_sys_i) begin
    hi_cnt <= busy_n ? hi_cnt + 1 : 0;
    if (!rst_i && $fell(fl_hv_reset_o)) begin
      hv_falls <= hv_falls + 1;
      check(32'(hi_cnt >= RRB), 32'h1);
    end
  end

  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    int n;
    repeat (11) @(posedge clk_sys_i);
    #1;
    check({26'h0, fl_strb_o, fl_dq_oe_o, irq_o, fl_reset_n_o}, 32'h38);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    reg_wr(nfc_pkg::REG_MASK, 32'h1);
    foreach (rows[i]) begin
      run_op(1'b0, rows[i].op, rows[i].a, rows[i].d);
      run_op(1'b0, nfc_pkg::OP_READ, rows[i].ra, 16'h0);
      reg_rd(nfc_pkg::REG_RDATA);
      check(got, {16'h0, rows[i].exp});
    end
    // a chip erase ordered while a program runs must be ignored
    reg_wr(nfc_pkg::REG_ADDR, 32'h00300);
    reg_wr(nfc_pkg::REG_DATA, 32'h1234);
    reg_wr(nfc_pkg::REG_CTRL, {29'h0, nfc_pkg::OP_PROG});
    reg_wr(nfc_pkg::REG_CTRL, {29'h0, nfc_pkg::OP_CHIP});
    wait_irq();
    reg_wr(nfc_pkg::REG_IRQ, 32'h7);
    run_op(1'b0, nfc_pkg::OP_READ, 20'h00300, 16'h0);
    reg_rd(nfc_pkg::REG_RDATA);
    check(got, 32'h1234);
    // masked completion sets the sticky bit but keeps the line low
    reg_wr(nfc_pkg::REG_MASK, 32'h0);
    reg_wr(nfc_pkg::REG_ADDR, 32'h00301);
    reg_wr(nfc_pkg::REG_DATA, 32'h00FF);
    reg_wr(nfc_pkg::REG_CTRL, {29'h0, nfc_pkg::OP_PROG});
    n = 0;
    got = 32'h0;
    while (got[0] !== 1'b1 && n < 500) begin
      reg_rd(nfc_pkg::REG_IRQ);
      check({31'h0, irq_o}, 32'h0);
      n++;
    end
    check(32'(n < 500), 32'h1);
    reg_wr(nfc_pkg::REG_MASK, 32'h1);
    #1;
    check({31'h0, irq_o}, 32'h1);
    reg_wr(nfc_pkg::REG_IRQ, 32'h7);
    #1;
    check({31'h0, irq_o}, 32'h0);
    // program under the high reset level, then protect and unprotect
    run_op(1'b1, nfc_pkg::OP_PROG, 20'h00302, 16'h8080);
    repeat (RRB + 4) @(posedge clk_sys_i);
    check(32'(hv_falls), 32'h1);
    run_op(1'b0, nfc_pkg::OP_PROT, 20'hFFFFF, 16'h0);
    check({27'h0, prot_pat}, {27'h0, nfc_pkg::PROTECT_PATTERN});
    run_op(1'b0, nfc_pkg::OP_UNPROT, 20'h00000, 16'h0);
    check({27'h0, prot_pat}, {27'h0, nfc_pkg::UNPROTECT_PATTERN});
    reg_rd(4'hF);
    check(got, 32'h0);
    // a write with the clock enable low must leave the mask untouched
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    reg_wr(nfc_pkg::REG_MASK, 32'h6);
    ce_i <= 1'b1;
    reg_rd(nfc_pkg::REG_MASK);
    check(got, 32'h1);
    // reset in the middle of a write pulse must idle the pins at once
    reg_wr(nfc_pkg::REG_CTRL, {29'h0, nfc_pkg::OP_CHIP});
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({26'h0, fl_strb_o, fl_dq_oe_o, irq_o, fl_reset_n_o}, 32'h38);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    reg_rd(nfc_pkg::REG_STATUS);
    check(got, 32'h10);
    give_verdict();
  end
endmodule : tb_top
